// file: baud_gen_pkg.sv
// constants shared by the serial baud rate generator and its helper modules
// assumes a single 10 MHz bus clock and an Avalon-MM master with waitrequest
//
// Behaviour
// - divisor is five high bits plus low byte
// - zero divisor stops the generator completely
// - bit rate is clock over sixteen times divisor
// - high byte buffered until low byte written
// - idle after reset until receiver/transmitter enabled
// - one common rate for transmit and receive
// - stop mode halts the generator
// - two independent interface instances
// - eight byte-wide registers per instance
package baud_gen_pkg;

    // ----------------------------------------------------------------
    // widths and counts
    // ----------------------------------------------------------------
    localparam int DIVISOR_WIDTH = 13;
    localparam int HIGH_WIDTH    = 5;
    localparam int LOW_WIDTH     = 8;
    localparam int OVERSAMPLE    = 16;
    localparam int PHASE_WIDTH   = 4;
    localparam int INSTANCE_MAX  = 2;
    localparam int ADDR_WIDTH    = 5;
    localparam int SYNC_STAGES   = 3;

    // ----------------------------------------------------------------
    // register indices inside one instance (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_DIV_HIGH   = 3'h0;
    localparam logic [2:0] REG_DIV_LOW    = 3'h1;
    localparam logic [2:0] REG_CTRL_ONE   = 3'h2;
    localparam logic [2:0] REG_CTRL_TWO   = 3'h3;
    localparam logic [2:0] REG_STATUS_ONE = 3'h4;
    localparam logic [2:0] REG_STATUS_TWO = 3'h5;
    localparam logic [2:0] REG_CTRL_THREE = 3'h6;
    localparam logic [2:0] REG_DATA       = 3'h7;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int INSTANCE_BIT   = 3;
    localparam int UNMAPPED_BIT   = 4;
    localparam int RX_ENABLE_BIT  = 2;
    localparam int TX_ENABLE_BIT  = 3;
    localparam int STAT_RUN_BIT   = 0;
    localparam int STAT_ARMED_BIT = 1;
    localparam int STAT_STOP_BIT  = 2;
    localparam int STAT_ZERO_BIT  = 3;

    // ----------------------------------------------------------------
    // values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
    localparam logic [7:0] DIV_LOW_RESET  = 8'h04;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] DATA_RESET     = 8'h00;

endpackage : baud_gen_pkg

// file: baud_link_if.sv
// interface between the register side and one baud tick generator
// assumes both ends share the bus clock
`timescale 1ns/1ps
`default_nettype none

interface baud_link_if;
    logic [12:0] divisor;
    logic        run;
    logic        rate_tick;
    logic        bit_tick;

    modport ctrl (output divisor, output run, input rate_tick, input bit_tick);
    modport gen  (input divisor, input run, output rate_tick, output bit_tick);
endinterface : baud_link_if

`default_nettype wire

// file: baud_tick_gen.sv
// 13-bit modulo divider making the oversampled rate tick and the bit tick
// assumes divisor and run come from the register side on the same clock
`timescale 1ns/1ps
`default_nettype none

module baud_tick_gen
    import baud_gen_pkg::*;
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst,
    // register side
    baud_link_if.gen    link
);

    logic [DIVISOR_WIDTH-1:0] count_reg;
    logic [PHASE_WIDTH-1:0]   phase_reg;
    logic                     rate_tick_reg;
    logic                     bit_tick_reg;
    logic                     wrap;

    // >= guards against a divisor lowered below the running count
    assign wrap = (count_reg >= link.divisor - 13'h0001);

    // ----------------------------------------------------------------
    // modulo counter
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst || !link.run)
        begin
            count_reg     <= '0;
            rate_tick_reg <= 1'b0;
        end
        else if (wrap)
        begin
            count_reg     <= '0;
            rate_tick_reg <= 1'b1;
        end
        else
        begin
            count_reg     <= count_reg + 13'h0001;
            rate_tick_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sixteen rate ticks make one bit time
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst || !link.run)
        begin
            phase_reg    <= '0;
            bit_tick_reg <= 1'b0;
        end
        else if (wrap)
        begin
            phase_reg    <= phase_reg + 4'h1;
            bit_tick_reg <= (phase_reg == 4'(OVERSAMPLE - 1));
        end
        else
        begin
            bit_tick_reg <= 1'b0;
        end
    end

    assign link.rate_tick = rate_tick_reg;
    assign link.bit_tick  = bit_tick_reg;

endmodule : baud_tick_gen

`default_nettype wire

// file: level_sync.sv
// three-stage synchroniser for a level arriving from a pin
// a change is accepted once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module level_sync
    import baud_gen_pkg::*;
(
    // clock and reset
    input  wire logic   clock,
    input  wire logic   rst,
    // level
    input  wire logic   async_in,
    output logic        level_out
);

    logic [SYNC_STAGES-1:0] stage_reg;
    logic                   level_reg;

    always_ff @(posedge clock)
    begin
        if (rst)
            stage_reg <= '0;
        else
            stage_reg <= {stage_reg[SYNC_STAGES-2:0], async_in};
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            level_reg <= 1'b0;
        else if (stage_reg[1] == stage_reg[2])
            level_reg <= stage_reg[2];
    end

    assign level_out = level_reg;

endmodule : level_sync

`default_nettype wire

// file: serial_baud_rate_generator.sv
// register banks and baud generators of the serial interface instances
// assumes an Avalon-MM master with waitrequest and a stop mode pin level
`timescale 1ns/1ps
`default_nettype none

module serial_baud_rate_generator
    import baud_gen_pkg::*;
#(
    parameter int INSTANCES = INSTANCE_MAX
)
(
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         rst,
    // avalon-mm slave
    input  wire logic [baud_gen_pkg::ADDR_WIDTH-1:0] address,
    input  wire logic                         read,
    input  wire logic                         write,
    input  wire logic [31:0]                  writedata,
    input  wire logic [3:0]                   byteenable,
    output logic      [31:0]                  readdata,
    output logic                              waitrequest,
    // chip power state, asynchronous
    input  wire logic                         stop_mode,
    // to receivers and transmitters
    output logic      [INSTANCES-1:0]         rate_tick,
    output logic      [INSTANCES-1:0]         bit_tick,
    output logic      [INSTANCES-1:0]         receiver_enable,
    output logic      [INSTANCES-1:0]         transmitter_enable,
    output logic      [INSTANCES-1:0]         generator_running
);

    import baud_gen_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // one address bit selects the instance, so at most two fit
    if (INSTANCES < 1 || INSTANCES > INSTANCE_MAX)
    begin : g_bad_instances
        $error("INSTANCES must be 1 or 2");
    end

    // the divisor is the high field stacked on the low byte
    if (HIGH_WIDTH + LOW_WIDTH != DIVISOR_WIDTH)
    begin : g_bad_divisor
        $error("divisor fields do not add up");
    end

    // one phase wrap must be exactly one bit time
    if (OVERSAMPLE != (1 << PHASE_WIDTH))
    begin : g_bad_phase
        $error("oversample count does not match phase width");
    end

    // unmapped bit must sit above the instance bit, inside the address
    if (UNMAPPED_BIT >= ADDR_WIDTH || INSTANCE_BIT >= UNMAPPED_BIT)
    begin : g_bad_address
        $error("address fields do not fit");
    end

    // arming only matters because the reset divisor is non-zero
    if (DIV_LOW_RESET == 8'h00)
    begin : g_bad_reset
        $error("reset divisor must be non-zero");
    end

    // the stop level is filtered by three flip-flops
    if (SYNC_STAGES < 3)
    begin : g_bad_sync
        $error("stop synchroniser needs three stages");
    end

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic owns(
        input logic [ADDR_WIDTH-1:0] addr,
        input int                    inst
    );
        owns = !addr[UNMAPPED_BIT] && (int'(addr[INSTANCE_BIT]) == inst);
    endfunction : owns

    function automatic logic hit(
        input logic [ADDR_WIDTH-1:0] addr,
        input int                    inst,
        input logic [2:0]            index
    );
        hit = owns(addr, inst) && (addr[2:0] == index);
    endfunction : hit

    function automatic logic [7:0] status_byte(
        input logic zero,
        input logic stopped,
        input logic armed,
        input logic running
    );
        status_byte                 = 8'h00;
        status_byte[STAT_ZERO_BIT]  = zero;
        status_byte[STAT_STOP_BIT]  = stopped;
        status_byte[STAT_ARMED_BIT] = armed;
        status_byte[STAT_RUN_BIT]   = running;
    endfunction : status_byte

    function automatic logic [DIVISOR_WIDTH-1:0] join_divisor(
        input logic [7:0] high,
        input logic [7:0] low
    );
        join_divisor = {high[HIGH_WIDTH-1:0], low};
    endfunction : join_divisor

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    logic        ack_reg;
    logic [31:0] readdata_reg;
    logic        write_now;
    logic        read_take;

    // every access waits exactly one cycle, reads get a registered answer
    always_ff @(posedge clock)
    begin
        if (rst)
            ack_reg <= 1'b0;
        else
            ack_reg <= (read || write) && !ack_reg;
    end

    assign waitrequest = (read || write) && !ack_reg;
    assign write_now   = write && ack_reg && byteenable[0];
    assign read_take   = read && !ack_reg;

    // ----------------------------------------------------------------
    // stop mode
    // ----------------------------------------------------------------
    logic stop_level;

    level_sync i_level_sync (
        .clock     (clock),
        .rst       (rst),
        .async_in  (stop_mode),
        .level_out (stop_level)
    );

    // ----------------------------------------------------------------
    // per instance registers
    // ----------------------------------------------------------------
    logic [7:0] div_high_buf_reg  [INSTANCES];
    logic [7:0] div_high_work_reg [INSTANCES];
    logic [7:0] div_low_reg       [INSTANCES];
    logic [7:0] ctrl_one_reg      [INSTANCES];
    logic [7:0] ctrl_two_reg      [INSTANCES];
    logic [7:0] ctrl_three_reg    [INSTANCES];
    logic [7:0] data_reg          [INSTANCES];
    logic       armed_reg         [INSTANCES];
    logic [7:0] status_one        [INSTANCES];
    logic [7:0] status_two        [INSTANCES];
    logic [DIVISOR_WIDTH-1:0] divisor [INSTANCES];
    logic       run               [INSTANCES];

    baud_link_if link [INSTANCES] ();

    for (genvar i = 0; i < INSTANCES; i++)
    begin : g_inst
        // high byte: software writes land in the buffer only
        always_ff @(posedge clock)
        begin
            if (rst)
                div_high_buf_reg[i] <= DIV_HIGH_RESET;
            else if (write_now && hit(address, i, REG_DIV_HIGH))
                div_high_buf_reg[i] <= {3'h0, writedata[HIGH_WIDTH-1:0]};
        end

        // working high half follows the buffer on a low byte write
        always_ff @(posedge clock)
        begin
            if (rst)
                div_high_work_reg[i] <= DIV_HIGH_RESET;
            else if (write_now && hit(address, i, REG_DIV_LOW))
                div_high_work_reg[i] <= div_high_buf_reg[i];
        end

        always_ff @(posedge clock)
        begin
            if (rst)
                div_low_reg[i] <= DIV_LOW_RESET;
            else if (write_now && hit(address, i, REG_DIV_LOW))
                div_low_reg[i] <= writedata[7:0];
        end

        // option bytes are stored and only read back, no port carries them out
        always_ff @(posedge clock)
        begin
            if (rst)
                ctrl_one_reg[i] <= CTRL_RESET;
            else if (write_now && hit(address, i, REG_CTRL_ONE))
                ctrl_one_reg[i] <= writedata[7:0];
        end

        always_ff @(posedge clock)
        begin
            if (rst)
                ctrl_three_reg[i] <= CTRL_RESET;
            else if (write_now && hit(address, i, REG_CTRL_THREE))
                ctrl_three_reg[i] <= writedata[7:0];
        end

        always_ff @(posedge clock)
        begin
            if (rst)
                data_reg[i] <= DATA_RESET;
            else if (write_now && hit(address, i, REG_DATA))
                data_reg[i] <= writedata[7:0];
        end

        always_ff @(posedge clock)
        begin
            if (rst)
                ctrl_two_reg[i] <= CTRL_RESET;
            else if (write_now && hit(address, i, REG_CTRL_TWO))
                ctrl_two_reg[i] <= writedata[7:0];
        end

        // reset divisor is non-zero, so an explicit arm keeps it quiet
        always_ff @(posedge clock)
        begin
            if (rst)
                armed_reg[i] <= 1'b0;
            else if (write_now && hit(address, i, REG_CTRL_TWO)
                     && (writedata[RX_ENABLE_BIT] || writedata[TX_ENABLE_BIT]))
                armed_reg[i] <= 1'b1;
        end

        assign divisor[i] = join_divisor(div_high_work_reg[i], div_low_reg[i]);
        assign run[i]     = armed_reg[i]
                            && (divisor[i] != '0)
                            && !stop_level;

        assign status_one[i] = status_byte((divisor[i] == '0), stop_level,
                                           armed_reg[i], run[i]);
        assign status_two[i] = {3'h0, div_high_work_reg[i][HIGH_WIDTH-1:0]};

        assign link[i].divisor = divisor[i];
        assign link[i].run     = run[i];

        // one generator serves both directions of the instance
        baud_tick_gen i_baud_tick_gen (
            .clock (clock),
            .rst   (rst),
            .link  (link[i])
        );

        assign rate_tick[i]          = link[i].rate_tick;
        assign bit_tick[i]           = link[i].bit_tick;
        assign receiver_enable[i]    = ctrl_two_reg[i][RX_ENABLE_BIT];
        assign transmitter_enable[i] = ctrl_two_reg[i][TX_ENABLE_BIT];
        assign generator_running[i]  = run[i];
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    logic [7:0] read_byte;

    always_comb
    begin
        read_byte = 8'h00;
        for (int i = 0; i < INSTANCES; i++)
        begin
            if (owns(address, i))
            begin
                case (address[2:0])
                    REG_DIV_HIGH:   read_byte = div_high_buf_reg[i];
                    REG_DIV_LOW:    read_byte = div_low_reg[i];
                    REG_CTRL_ONE:   read_byte = ctrl_one_reg[i];
                    REG_CTRL_TWO:   read_byte = ctrl_two_reg[i];
                    REG_STATUS_ONE: read_byte = status_one[i];
                    REG_STATUS_TWO: read_byte = status_two[i];
                    REG_CTRL_THREE: read_byte = ctrl_three_reg[i];
                    REG_DATA:       read_byte = data_reg[i];
                    default:        read_byte = 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    // unmapped addresses answer zero, narrow data sits in the low byte
    always_ff @(posedge clock)
    begin
        if (rst)
            readdata_reg <= 32'h0000_0000;
        else if (read_take)
            readdata_reg <= {24'h00_0000, read_byte};
    end

    assign readdata = readdata_reg;

endmodule : serial_baud_rate_generator

`default_nettype wire

// file: serial_baud_rate_generator_props.sv
// checker for the baud rate generator, watching top-level ports only
// assumes one bus clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module serial_baud_rate_generator_props
    import baud_gen_pkg::*;
#(
    parameter int INSTANCES = INSTANCE_MAX
)
(
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    // bus
    input wire logic [ADDR_WIDTH-1:0] address,
    input wire logic                  read,
    input wire logic                  write,
    input wire logic [31:0]           writedata,
    input wire logic [3:0]            byteenable,
    input wire logic [31:0]           readdata,
    input wire logic                  waitrequest,
    // generator side
    input wire logic                  stop_mode,
    input wire logic [INSTANCES-1:0]  rate_tick,
    input wire logic [INSTANCES-1:0]  bit_tick,
    input wire logic [INSTANCES-1:0]  receiver_enable,
    input wire logic [INSTANCES-1:0]  transmitter_enable,
    input wire logic [INSTANCES-1:0]  generator_running
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // enable seen since reset; arming never clears, enables may
    logic seen_reg;
    always_ff @(posedge clock)
    begin
        if (rst)
            seen_reg <= 1'b0;
        else if (receiver_enable[0] || transmitter_enable[0])
            seen_reg <= 1'b1;
    end

    sequence s_req; (read || write) && waitrequest; endsequence
    sequence s_ack; !waitrequest; endsequence
    property p_wait; s_req |=> s_ack; endproperty
    a_wait: assert property (p_wait) else $error("wait longer than one cycle");
    property p_upper; read && !waitrequest |-> readdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_unmapped; read && !waitrequest && address[4] |-> readdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl;
        write && !waitrequest && address == 5'h03 && byteenable[0] |=>
            receiver_enable[0] == $past(writedata[2])
            && transmitter_enable[0] == $past(writedata[3]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("enable bits not stored");
    property p_indep; write && address[3] |=> $stable(receiver_enable[0]); endproperty
    a_indep: assert property (p_indep) else $error("instances not independent");
    property p_arm;
        generator_running[0] |-> seen_reg || receiver_enable[0] || transmitter_enable[0];
    endproperty
    a_arm: assert property (p_arm) else $error("running before enable");
    property p_stop; stop_mode [*5] |-> !generator_running[0]; endproperty
    a_stop: assert property (p_stop) else $error("running in stop mode");
    property p_idle; !generator_running[0] ##1 !generator_running[0] |-> !rate_tick[0]; endproperty
    a_idle: assert property (p_idle) else $error("tick while idle");
    property p_tick; rate_tick[0] |-> $past(generator_running[0]); endproperty
    a_tick: assert property (p_tick) else $error("tick without run");
    property p_bit; bit_tick[0] |=> !bit_tick[0]; endproperty
    a_bit: assert property (p_bit) else $error("bit tick too long");
endmodule : serial_baud_rate_generator_props

bind serial_baud_rate_generator serial_baud_rate_generator_props #(.INSTANCES(INSTANCES)) i_props (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .stop_mode(stop_mode), .rate_tick(rate_tick),
    .bit_tick(bit_tick), .receiver_enable(receiver_enable),
    .transmitter_enable(transmitter_enable), .generator_running(generator_running));

`default_nettype wire

// file: serial_baud_rate_generator_test.sv
// self-checking bench: register reads, idle and stop behaviour, tick spacing
// assumes the bound checker file is compiled alongside
`timescale 1ns/1ps
`default_nettype none

module serial_baud_rate_generator_test;
    import baud_gen_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  address = 5'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hF;
    logic        stop_mode = 1'b0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  rate_tick, bit_tick, receiver_enable, transmitter_enable, generator_running;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'hFD67;
    int          errors = 0;
    int          n_compared = 0;
    int          r;

    always #50 clock = ~clock;

    serial_baud_rate_generator i_serial_baud_rate_generator (
        .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .stop_mode(stop_mode), .rate_tick(rate_tick),
        .bit_tick(bit_tick), .receiver_enable(receiver_enable),
        .transmitter_enable(transmitter_enable), .generator_running(generator_running));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    // one bounded wait for waitrequest low, shared by reads and writes
    task automatic wait_ack();
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
        begin
            errors++;
            print_verdict();
        end
    endtask : wait_ack

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        address <= a;
        writedata <= {24'h0, d};
        write <= 1'b1;
        wait_ack();
        write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        address <= a;
        read <= 1'b1;
        wait_ack();
        read <= 1'b0;
        @(posedge clock);
    endtask : rd

    // read data are compared by this watcher, in request order
    always @(posedge clock)
    begin
        if (!rst && read && waitrequest === 1'b0)
        begin
            if (exp_q.size() == 0)
                check("queue", 32'h1, 32'h0);
            else
                check("readdata", readdata, exp_q.pop_front());
        end
    end

    // spacing between the second and third tick; the first may follow an old count
    task automatic gap(input int i, input bit b, input int e);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge clock);
                n++;
            end while ((b ? bit_tick[i] : rate_tick[i]) !== 1'b1 && n < 9000);
            if (n >= 9000)
            begin
                errors++;
                print_verdict();
            end
        end
        check(b ? "bit gap" : "rate gap", 32'(n), 32'(e));
    endtask : gap

    task automatic quiet(input int i, input int len);
        int c;
        c = 0;
        repeat (len)
        begin
            @(posedge clock);
            if (rate_tick[i] !== 1'b0)
                c++;
        end
        check("idle ticks", 32'(c), 32'h0);
    endtask : quiet

    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(5'h00, 32'h00);
        rd(5'h01, 32'h04);
        rd(5'h03, 32'h00);
        rd(5'h04, 32'h00);
        rd(5'h10, 32'h00);
        quiet(0, 40);
        $display("test reset done");
        wr(5'h03, 8'h04);
        check("rx enable", 32'(receiver_enable), 32'h1);
        rd(5'h04, 32'h03);
        gap(0, 0, 4);
        gap(0, 1, 64);
        quiet(1, 40);
        wr(5'h04, 8'hFF);
        rd(5'h04, 32'h03);
        $display("test enable done");
        wr(5'h00, 8'h21);
        rd(5'h00, 32'h01);
        rd(5'h05, 32'h00);
        gap(0, 0, 4);
        r = int'(xs() & 32'hFF);
        wr(5'h01, r[7:0]);
        rd(5'h05, 32'h01);
        gap(0, 0, 256 + r);
        $display("test buffer done");
        wr(5'h00, 8'h00);
        wr(5'h01, 8'h00);
        rd(5'h04, 32'h0A);
        quiet(0, 40);
        wr(5'h01, 8'h01);
        gap(0, 0, 1);
        gap(0, 1, 16);
        for (int k = 0; k < 3; k++)
        begin
            r = 2 + int'(xs() % 32'd30);
            wr(5'h01, r[7:0]);
            gap(0, 0, r);
        end
        $display("test divisor done");
        stop_mode <= 1'b1;
        repeat (6) @(posedge clock);
        quiet(0, 40);
        rd(5'h04, 32'h06);
        stop_mode <= 1'b0;
        repeat (6) @(posedge clock);
        gap(0, 0, r);
        $display("test stop done");
        wr(5'h0B, 8'h08);
        check("tx enable", 32'(transmitter_enable), 32'h2);
        byteenable <= 4'hE;
        wr(5'h0B, 8'h00);
        byteenable <= 4'hF;
        rd(5'h0B, 32'h08);
        gap(1, 0, 4);
        rd(5'h01, 32'(r));
        $display("test second instance done");
        repeat (4) @(posedge clock);
        check("queue left", 32'(exp_q.size()), 32'h0);
        print_verdict();
    end
endmodule : serial_baud_rate_generator_test

`default_nettype wire
